// File: verilog/rtdr_defines.svh
// Offsets, field positions, reset values and constants of the debug reset and id registers.
// Assumes inclusion by bare name from design files; definitions only.
//
// Notes on behaviour
// R01 - Bit 0 of the reset acknowledge register reads 1 only after reset completes.
// R02 - Power-on reset clears both request and done bits.
// R03 - Writing 1 to request bit holds request until software writes 0.
// R04 - Requests are ignored while invasive debug is disabled.
// R05 - Optionally the debug reset clears the request bit, completing the sequence.
// R06 - Debugger must not clear the request before done reads 1.
// R07 - Separate status bits report whether request and acknowledge registers exist.
// R08 - Acknowledge register at 0xC14, read-only, upper bits zero.
// R09 - Request register at 0xC10, read-write, upper bits reserved zero.
// R10 - Two read-only affinity words read as all zeros.
// R11 - Architecture id: architect, present 1, revision 0, architecture code fields.
// R12 - Architecture id register decoded at 0xFBC.
// R13 - Debugger reads type and capability registers after finding the table code.
// R14 - Capability bit 5 shows power-request control and its id register present.
// R15 - Without power-request control, power domains need a separate power requester.
// R16 - Capability bit 4 shows system memory on the table's bus.
// R17 - Without system memory, debugger touches only table-listed addresses.
// R18 - Capability bits 3..0 give entry format: 0 for 32-bit, 1 for 64-bit.
// R19 - Capability register at 0xFCC, bits 31..6 read zero.
// R20 - Done set only after completed reset, cleared after request removal.
// R21 - Writes to read-only registers and reserved bits have no effect.
`ifndef RTDR_DEFINES_SVH
`define RTDR_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define RTDR_OFS_RST_REQ 12'hC10
`define RTDR_OFS_RST_ACK 12'hC14
`define RTDR_OFS_PWR_ID 12'hC18
`define RTDR_OFS_AFF0 12'hFA8
`define RTDR_OFS_AFF1 12'hFAC
`define RTDR_OFS_ARCH_ID 12'hFBC
`define RTDR_OFS_CAPS 12'hFCC

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RTDR_BIT_REQ 0
`define RTDR_BIT_DONE 0
`define RTDR_BIT_PWRID_REQ 0
`define RTDR_BIT_PWRID_ACK 1
`define RTDR_BIT_PRES 20
`define RTDR_BIT_PWR_INCL 5
`define RTDR_BIT_SYS_MEM 4

// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define RTDR_RST_REQ_VAL 1'h0
`define RTDR_RST_DONE_VAL 1'h0
`define RTDR_ARCH_REV 4'h0
`define RTDR_FMT_32 4'h0
`define RTDR_FMT_64 4'h1
`define RTDR_ERR_DATA 32'hDEADBEEF

`endif

// File: verilog/rtdr_pkg.sv
// Types shared by the debug reset and id register bank.
// Assumes no other package.
`default_nettype none
package rtdr_pkg;

    typedef enum logic [3:0] {
        RTDR_IDLE = 4'h1,
        RTDR_RESET = 4'h2,
        RTDR_DONE = 4'h4,
        RTDR_DRAIN = 4'h8
    } rtdr_state_type;

    typedef struct packed {
        logic read;
        logic write;
        logic [11:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } rtdr_req_type;

endpackage
`default_nettype wire

// File: verilog/rtdr_regs.sv
// Debug reset request/acknowledge handshake, affinity, architecture id and capability registers.
// Assumes an Avalon-MM master on CLK_SYS_I and a debug reset target that pulses completion.
`timescale 1ns/1ps
`default_nettype none
`include "rtdr_defines.svh"

module rtdr_regs #(
    parameter logic [10:0] ARCHITECT_CODE = 11'h001,  // Arbitrary neutral value
    parameter logic [15:0] ARCH_CODE = 16'h0001,      // Arbitrary neutral value
    parameter bit RESET_CLEARS_REQ = 1'b0,
    parameter bit PWR_REQ_INCLUDED = 1'b1,
    parameter bit SYS_MEM_PRESENT = 1'b0,
    parameter logic [3:0] ENTRY_FORMAT = `RTDR_FMT_32
) (
    // Clock and reset
    input wire logic CLK_SYS_I,
    input wire logic ARST_N_I,
    // Avalon-MM slave
    input wire logic [11:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    output logic [31:0] AVS_READDATA_O,
    output logic [1:0] AVS_RESPONSE_O,
    output logic AVS_WAITREQUEST_O,
    // Debug reset target
    input wire logic INVASIVE_EN_I,
    input wire logic DBG_RST_DONE_I,
    output logic DBG_RST_REQ_O
);

    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    // Reserved format codes would mislead the debugger
    if (ENTRY_FORMAT > `RTDR_FMT_64) begin : g_bad_format
        $error("ENTRY_FORMAT reserved code");
    end

    // ----------------------------------------
    // Reset synchroniser
    // ----------------------------------------
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ----------------------------------------
    // Bus request and one-cycle wait
    // ----------------------------------------
    rtdr_pkg::rtdr_req_type req;
    logic ack;
    logic wr_fire;
    logic rd_fire;
    assign req = '{read: AVS_READ_I, write: AVS_WRITE_I, address: AVS_ADDRESS_I,
                   byteenable: AVS_BYTEENABLE_I, writedata: AVS_WRITEDATA_I};
    // One wait cycle keeps read data registered
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            ack <= 1'b0;
        end else begin
            ack <= (req.read || req.write) && !ack;
        end
    end
    assign AVS_WAITREQUEST_O = (req.read || req.write) && !ack;
    assign wr_fire = req.write && ack;
    assign rd_fire = req.read && !ack;

    // ----------------------------------------
    // Reset handshake
    // ----------------------------------------
    rtdr_pkg::rtdr_state_type state;
    logic req_bit;
    logic done_bit;
    logic req_wr;
    logic req_val;
    assign req_wr = wr_fire && req.address == `RTDR_OFS_RST_REQ && req.byteenable[0];
    assign req_val = req.writedata[`RTDR_BIT_REQ];

    // Request bit held until software writes 0, or with RESET_CLEARS_REQ until the reset completes [R03]
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            req_bit <= `RTDR_RST_REQ_VAL; // [R02]
        end else if (req_wr && (INVASIVE_EN_I || !req_val)) begin
            req_bit <= req_val; // [R04] [R21]
        end else if (RESET_CLEARS_REQ && state == rtdr_pkg::RTDR_RESET && DBG_RST_DONE_I) begin
            req_bit <= 1'b0; // [R05]
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            state <= rtdr_pkg::RTDR_IDLE;
            done_bit <= `RTDR_RST_DONE_VAL; // [R02]
        end else begin
            case (state)
                rtdr_pkg::RTDR_IDLE: begin
                    if (req_bit) begin
                        state <= rtdr_pkg::RTDR_RESET;
                    end
                end
                rtdr_pkg::RTDR_RESET: begin
                    if (DBG_RST_DONE_I) begin
                        // Self-clearing build reports completion by the request returning low
                        state <= RESET_CLEARS_REQ ? rtdr_pkg::RTDR_IDLE : rtdr_pkg::RTDR_DONE;
                        done_bit <= !RESET_CLEARS_REQ; // [R01] [R20]
                    end
                end
                rtdr_pkg::RTDR_DONE: begin
                    // Early clear is the debugger's fault; treated as plain removal [R06]
                    if (!req_bit) begin
                        state <= rtdr_pkg::RTDR_IDLE;
                        done_bit <= 1'b0; // [R20]
                    end
                end
                default: begin
                    state <= rtdr_pkg::RTDR_IDLE;
                    done_bit <= 1'b0;
                end
            endcase
        end
    end
    assign DBG_RST_REQ_O = state == rtdr_pkg::RTDR_RESET;

    // ----------------------------------------
    // Read mux, registered
    // ----------------------------------------
    logic [31:0] next_rdata;
    logic next_err;
    always_comb begin
        next_rdata = 32'h00000000;
        next_err = 1'b0;
        case (req.address)
            `RTDR_OFS_RST_REQ: next_rdata[`RTDR_BIT_REQ] = req_bit; // [R09]
            `RTDR_OFS_RST_ACK: next_rdata[`RTDR_BIT_DONE] = done_bit; // [R08] [R01]
            `RTDR_OFS_PWR_ID: begin
                next_rdata[`RTDR_BIT_PWRID_REQ] = PWR_REQ_INCLUDED; // [R07]
                next_rdata[`RTDR_BIT_PWRID_ACK] = PWR_REQ_INCLUDED; // [R07]
            end
            `RTDR_OFS_AFF0, `RTDR_OFS_AFF1: next_rdata = 32'h00000000; // [R10]
            `RTDR_OFS_ARCH_ID: next_rdata = {ARCHITECT_CODE, 1'b1, `RTDR_ARCH_REV, ARCH_CODE}; // [R11] [R12]
            `RTDR_OFS_CAPS: begin
                next_rdata[`RTDR_BIT_PWR_INCL] = PWR_REQ_INCLUDED; // [R14] [R15]
                next_rdata[`RTDR_BIT_SYS_MEM] = SYS_MEM_PRESENT; // [R16] [R17]
                next_rdata[3:0] = ENTRY_FORMAT; // [R18] [R19] [R13]
            end
            default: begin
                next_rdata = 32'h00000000;
                next_err = 1'b1;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            AVS_READDATA_O <= 32'h00000000;
            AVS_RESPONSE_O <= 2'h0;
        end else if (rd_fire) begin
            AVS_READDATA_O <= next_rdata;
            AVS_RESPONSE_O <= next_err ? 2'h3 : 2'h0;
        end else if (req.write && !ack) begin
            AVS_RESPONSE_O <= next_err ? 2'h3 : 2'h0;
        end
    end

endmodule // rtdr_regs
`default_nettype wire

// File: verification/rtdr_chk.sv
// Port assertions for the debug reset and id register bank.
// Assumes a bind to rtdr_regs built with its default options.
`timescale 1ns/1ps
`default_nettype none
module rtdr_chk (
    // Watched ports
    input wire logic CLK_SYS_I,
    input wire logic ARST_N_I,
    input wire logic [11:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [31:0] AVS_READDATA_O,
    input wire logic [1:0] AVS_RESPONSE_O,
    input wire logic AVS_WAITREQUEST_O,
    input wire logic INVASIVE_EN_I,
    input wire logic DBG_RST_DONE_I,
    input wire logic DBG_RST_REQ_O
);
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (!ARST_N_I);
    wire logic rdc = AVS_READ_I & ~AVS_WAITREQUEST_O;
    wire logic set1 = AVS_WRITE_I & ~AVS_WAITREQUEST_O & AVS_BYTEENABLE_I[0]
        & (AVS_ADDRESS_I == 12'hC10) & AVS_WRITEDATA_I[0] & ~DBG_RST_REQ_O;
    ack_bits_a: assert property (rdc && AVS_ADDRESS_I == 12'hC14 |-> AVS_READDATA_O[31:1] == '0)
        else $error("ack upper bits set");
    req_bits_a: assert property (rdc && AVS_ADDRESS_I == 12'hC10 |-> AVS_READDATA_O[31:1] == '0)
        else $error("request upper bits set");
    affinity_zero_a: assert property (rdc && AVS_ADDRESS_I[11:3] == 9'h1F5 |-> AVS_READDATA_O == '0)
        else $error("affinity not zero");
    arch_fields_a: assert property (rdc && AVS_ADDRESS_I == 12'hFBC |-> AVS_READDATA_O[20:16] == 5'h10)
        else $error("arch id fields wrong");
    caps_fields_a: assert property (rdc && AVS_ADDRESS_I == 12'hFCC |->
        AVS_READDATA_O[31:6] == '0 && AVS_READDATA_O[3:1] == 3'h0) else $error("caps fields wrong");
    gated_req_a: assert property (set1 && !INVASIVE_EN_I |=> !DBG_RST_REQ_O [*3])
        else $error("request not gated");
    start_req_a: assert property (set1 && INVASIVE_EN_I |-> ##[1:2] DBG_RST_REQ_O)
        else $error("request not started");
    req_hold_a: assert property (DBG_RST_REQ_O && !DBG_RST_DONE_I |=> DBG_RST_REQ_O)
        else $error("request dropped early");
    req_end_a: assert property (DBG_RST_REQ_O && DBG_RST_DONE_I |=> !DBG_RST_REQ_O)
        else $error("request kept after done");
endmodule // rtdr_chk
`default_nettype wire

// File: verification/rtdr_tgt.sv
// Debug reset target model: completes a reset a few cycles after the request.
// Assumes the request is a level held until completion.
`timescale 1ns/1ps
`default_nettype none
module rtdr_tgt (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic req_i,
    output logic done_o
);
    logic [2:0] n;
    // Completion pulse only after the reset has run
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            n <= 3'h0;
            done_o <= 1'b0;
        end else begin
            n <= req_i ? n + 3'h1 : 3'h0;
            done_o <= req_i && n == 3'h4;
        end
    end
endmodule // rtdr_tgt
`default_nettype wire

// File: verification/tb_top.sv
// Bench for the debug reset and id register bank.
// Assumes the checker and the reset target model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, inv = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [3:0] be = 4'hF;
    logic [31:0] wd = 32'h0, q, rdat;
    logic [1:0] rs, resp;
    logic wt, req, done;
    int err_count = 0, checks = 0, cyc = 0;
    logic [11:0] ra [6] = '{12'hC14, 12'hC18, 12'hFA8, 12'hFAC, 12'hFBC, 12'hFCC};
    logic [31:0] rv [6] = '{32'h0, 32'h3, 32'h0, 32'h0, 32'h00300001, 32'h20};
    rtdr_regs dut_u (.CLK_SYS_I(clk), .ARST_N_I(rst_n), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
        .AVS_WRITE_I(wr), .AVS_BYTEENABLE_I(be), .AVS_WRITEDATA_I(wd), .AVS_READDATA_O(rdat),
        .AVS_RESPONSE_O(resp), .AVS_WAITREQUEST_O(wt), .INVASIVE_EN_I(inv),
        .DBG_RST_DONE_I(done), .DBG_RST_REQ_O(req));
    rtdr_tgt tgt_u (.clk_i(clk), .rst_n_i(rst_n), .req_i(req), .done_o(done));
    initial forever #5 clk = ~clk;
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Hang guard far above the hundred-odd cycles needed
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            give_verdict();
        end
    end
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do @(posedge clk); while (wt !== 1'b0);
        q = rdat;
        rs = resp;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        xfer(1'b0, 12'hC10, 32'h0);
        chk("request word", 32'h0, q);
        foreach (ra[i]) begin
            xfer(1'b1, ra[i], 32'hFFFFFFFF);
            xfer(1'b0, ra[i], 32'h0);
            chk("fixed word", rv[i], q);
        end
        xfer(1'b0, 12'h000, 32'h0);
        chk("unmapped response", 32'h3, {30'h0, rs});
        $display("test fixed words done");
        xfer(1'b1, 12'hC10, 32'hFFFFFFFF);
        xfer(1'b0, 12'hC10, 32'h0);
        chk("gated request", 32'h0, q);
        inv <= 1'b1;
        // Byte lane 0 off: the request bit must not move
        be <= 4'hE;
        xfer(1'b1, 12'hC10, 32'hFFFFFFFF);
        be <= 4'hF;
        xfer(1'b0, 12'hC10, 32'h0);
        chk("masked request", 32'h0, q);
        xfer(1'b1, 12'hC10, 32'hFFFFFFFF);
        xfer(1'b0, 12'hC10, 32'h0);
        chk("request set", 32'h1, q);
        do xfer(1'b0, 12'hC14, 32'h0); while (q[0] !== 1'b1);
        xfer(1'b0, 12'hC10, 32'h0);
        chk("request held", 32'h1, q);
        xfer(1'b1, 12'hC10, 32'h0);
        xfer(1'b0, 12'hC14, 32'h0);
        chk("done cleared", 32'h0, q);
        $display("test reset handshake done");
        xfer(1'b1, 12'hC10, 32'h1);
        do xfer(1'b0, 12'hC14, 32'h0); while (q[0] !== 1'b1);
        // Reset lands with request and acknowledge both set
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        xfer(1'b0, 12'hC10, 32'h0);
        chk("request after reset", 32'h0, q);
        xfer(1'b0, 12'hC14, 32'h0);
        chk("done after reset", 32'h0, q);
        $display("test mid-run reset done");
        give_verdict();
    end
endmodule // tb_top
bind rtdr_regs rtdr_chk chk_u (.CLK_SYS_I(CLK_SYS_I), .ARST_N_I(ARST_N_I),
    .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
    .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
    .AVS_READDATA_O(AVS_READDATA_O), .AVS_RESPONSE_O(AVS_RESPONSE_O),
    .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .INVASIVE_EN_I(INVASIVE_EN_I),
    .DBG_RST_DONE_I(DBG_RST_DONE_I), .DBG_RST_REQ_O(DBG_RST_REQ_O));
`default_nettype wire
